// ### xad_pkg.sv
// shared constants, types and state layout of the audio sector decoder
`default_nettype none
package xad_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] XAD_CTRL_OFS = 8'h00;
    localparam logic [7:0] XAD_STAT_OFS = 8'h04;
    localparam logic [7:0] XAD_CNT_OFS = 8'h08;
    localparam logic [31:0] XAD_CTRL_MASK = 32'h001FFF01;
    localparam logic [31:0] XAD_CTRL_RST = 32'h00000000;
    localparam logic [1:0] XAD_OKAY = 2'h0;
    localparam logic [1:0] XAD_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // sector layout
    // ----------------------------------------------------------------
    localparam logic [2:0] XAD_SUBHDR_LAST = 3'h7;
    localparam logic [4:0] XAD_PORTION_LAST = 5'h11;
    localparam logic [6:0] XAD_BYTE_LAST = 7'h7F;
    localparam logic [6:0] XAD_HDR_LEN = 7'h10;
    localparam logic [4:0] XAD_WORD_LAST = 5'h1B;
    localparam logic [3:0] XAD_PAR_BASE = 4'h4;
    localparam logic [3:0] XAD_DUP_HI = 4'h8;
    localparam int XAD_SM_AUDIO = 2;
    localparam int XAD_SM_FORM2 = 5;
    localparam int XAD_SM_RT = 6;
    localparam logic [1:0] XAD_CODE_ONE = 2'h1;
    // ----------------------------------------------------------------
    // sample expansion and prediction
    // ----------------------------------------------------------------
    localparam logic [3:0] XAD_SHIFT_MAX = 4'hC;
    localparam logic [3:0] XAD_SHIFT_ALT = 4'h9;
    localparam logic [31:0] XAD_POS = 32'h62733C00;
    localparam logic [31:0] XAD_NEG = 32'hC9CC0000;
    localparam logic signed [24:0] XAD_ROUND = 25'h0000020;
    localparam int XAD_DIV_SH = 6;
    localparam logic signed [24:0] XAD_PCM_MAX = 25'h0007FFF;
    localparam logic signed [24:0] XAD_PCM_MIN = 25'h1FF8000;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {XAD_HDR, XAD_FILL, XAD_DEC, XAD_SKIP} xad_st_t;
    typedef struct packed {
        logic upd;
        logic ch;
        logic [1:0] filt;
        logic [15:0] smp;
    } xad_pin_t;
    typedef struct packed {
        logic [1:0][15:0] old;
        logic [1:0][15:0] older;
    } xad_hist_t;
    typedef struct packed {
        xad_st_t st;
        logic rdy;
        logic [2:0] hcnt;
        logic [7:0] file;
        logic [4:0] chan;
        logic [7:0] sm;
        logic [7:0] cod;
        logic [4:0] por;
        logic [6:0] pidx;
        logic [15:0] herr;
        logic perr;
        logic [1:0] grp;
        logic [4:0] j;
        logic sub;
        logic [15:0] pcm;
        logic pright;
        logic pv;
        logic [31:0] ctrl;
        logic [15:0] nsec;
        logic [15:0] nerr;
        logic aw_got;
        logic [7:0] awa;
        logic w_got;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awrdy;
        logic wrdy;
        logic bv;
        logic [1:0] bresp;
        logic arrdy;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rresp;
    } xad_state_t;
endpackage
`default_nettype wire

// ### xad_predict.sv
// two-tap predictor with per-channel history and 16-bit clamp
`timescale 1ns/100ps
`default_nettype none
module xad_predict
    import xad_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire xad_pin_t in_i,
    output logic [15:0] pcm_o
);
    xad_hist_t r;
    xad_hist_t next_r;
    logic signed [7:0] f0;
    logic signed [7:0] f1;
    logic signed [24:0] acc;
    logic signed [24:0] sum;

    // ----------------------------------------------------------------
    // prediction and clamp
    // ----------------------------------------------------------------
    always_comb begin
        f0 = $signed(XAD_POS[{in_i.filt, 3'b000} +: 8]);
        f1 = $signed(XAD_NEG[{in_i.filt, 3'b000} +: 8]);
        acc = 25'($signed(r.old[in_i.ch]) * f0) + 25'($signed(r.older[in_i.ch]) * f1) + XAD_ROUND;
        sum = 25'($signed(in_i.smp)) + (acc >>> XAD_DIV_SH);
        if (sum > XAD_PCM_MAX) begin
            pcm_o = XAD_PCM_MAX[15:0];
        end else if (sum < XAD_PCM_MIN) begin
            pcm_o = XAD_PCM_MIN[15:0];
        end else begin
            pcm_o = sum[15:0];
        end
        next_r = r;
        if (in_i.upd) begin
            next_r.older[in_i.ch] = r.old[in_i.ch];
            next_r.old[in_i.ch] = pcm_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_hist;
        (in_i.upd && !in_i.ch) |=> (r.old[0] == $past(pcm_o)) && (r.older[0] == $past(r.old[0]));
    endproperty
    a_hist: assert property (p_hist) else $error("left history not advanced");

    property p_keep;
        (!in_i.upd) |=> $stable(r.old) && $stable(r.older);
    endproperty
    a_keep: assert property (p_keep) else $error("history moved without a sample");
endmodule
`default_nettype wire

// ### xad_decoder.sv
// sector selection, portion unpacking and register slave of the audio decoder
`timescale 1ns/100ps
`default_nettype none
module xad_decoder
    import xad_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic [7:0] SEC_DATA_I,
    input wire logic SEC_VALID_I,
    input wire logic SEC_FIRST_I,
    input wire logic SEC_ERR_I,
    output logic SEC_READY_O,
    output logic [15:0] PCM_O,
    output logic PCM_RIGHT_O,
    output logic PCM_VALID_O,
    input wire logic PCM_READY_I,
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I
);
    xad_state_t r;
    xad_state_t next_r;
    logic [7:0] mem [128];
    logic acc;
    logic free;
    logic stereo;
    logic eight;
    logic rt;
    logic match;
    logic drop;
    logic pdone;
    logic dlast;
    logic [2:0] blk;
    logic [3:0] pidx_hdr;
    logic [3:0] dupidx;
    logic [7:0] par;
    logic [3:0] shamt;
    logic [1:0] bsel;
    logic [7:0] raw;
    logic [15:0] wide;
    xad_pin_t pin;
    logic [15:0] pred;

    // ----------------------------------------------------------------
    // sample selection from the held portion
    // ----------------------------------------------------------------
    always_comb begin
        stereo = (r.cod[1:0] == XAD_CODE_ONE);
        eight = (r.cod[5:4] == XAD_CODE_ONE);
        rt = r.sm[XAD_SM_RT];
        blk = {r.grp, r.sub};
        pidx_hdr = XAD_PAR_BASE + {1'b0, blk};
        dupidx = blk[2] ? (XAD_DUP_HI + {1'b0, blk}) : {1'b0, blk};
        par = r.herr[pidx_hdr] ? mem[dupidx] : mem[pidx_hdr];
        shamt = (par[3:0] > XAD_SHIFT_MAX) ? XAD_SHIFT_ALT : par[3:0];
        bsel = eight ? blk[1:0] : blk[2:1];
        raw = mem[{r.j, 2'b00} + XAD_HDR_LEN + {5'h00, bsel}];
        if (eight) begin
            wide = {raw, 8'h00};
        end else if (blk[0]) begin
            wide = {raw[7:4], 12'h000};
        end else begin
            wide = {raw[3:0], 12'h000};
        end
        free = !r.pv || PCM_READY_I;
        pin.upd = (r.st == XAD_DEC) && free;
        pin.ch = stereo & r.sub;
        pin.filt = par[5:4];
        pin.smp = 16'($signed(wide) >>> shamt);
    end

    xad_predict u_predict (
        .clk_i(CLK_SYS_I),
        .rstn_i(RSTN_I),
        .in_i(pin),
        .pcm_o(pred)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        acc = SEC_VALID_I && r.rdy;
        match = r.ctrl[0] && (r.file == r.ctrl[15:8]) && (r.chan == r.ctrl[20:16])
            && r.sm[XAD_SM_AUDIO] && r.sm[XAD_SM_FORM2];
        drop = (r.perr || SEC_ERR_I) && !rt;
        pdone = 1'b0;
        dlast = (r.grp == (eight ? 2'h1 : 2'h3)) && (r.j == XAD_WORD_LAST) && r.sub;
        if (r.pv && PCM_READY_I) begin
            next_r.pv = 1'b0;
        end
        if (acc && SEC_FIRST_I) begin
            next_r.st = XAD_HDR;
            next_r.file = SEC_DATA_I;
            next_r.hcnt = 3'h1;
        end else begin
            case (r.st)
                XAD_HDR: begin
                    if (acc) begin
                        case (r.hcnt)
                            3'h0: next_r.file = SEC_DATA_I;
                            3'h1: next_r.chan = SEC_DATA_I[4:0];
                            3'h2: next_r.sm = SEC_DATA_I;
                            3'h3: next_r.cod = SEC_DATA_I;
                            default: next_r.hcnt = r.hcnt;
                        endcase
                        next_r.hcnt = r.hcnt + 3'h1;
                        if (r.hcnt == XAD_SUBHDR_LAST) begin
                            if (match) begin
                                next_r.st = XAD_FILL;
                                next_r.por = '0;
                                next_r.pidx = '0;
                                next_r.herr = '0;
                                next_r.perr = 1'b0;
                                next_r.nsec = r.nsec + 16'h0001;
                            end else begin
                                next_r.st = XAD_SKIP;
                            end
                        end
                    end
                end
                XAD_FILL: begin
                    if (acc) begin
                        if (SEC_ERR_I && (r.pidx < XAD_HDR_LEN)) begin
                            next_r.herr[r.pidx[3:0]] = 1'b1;
                        end
                        next_r.perr = r.perr || SEC_ERR_I;
                        next_r.pidx = r.pidx + 7'h01;
                        if (r.pidx == XAD_BYTE_LAST) begin
                            if (drop) begin
                                next_r.nerr = r.nerr + 16'h0001;
                                pdone = 1'b1;
                            end else begin
                                next_r.st = XAD_DEC;
                                next_r.grp = '0;
                                next_r.j = '0;
                                next_r.sub = 1'b0;
                            end
                        end
                    end
                end
                XAD_DEC: begin
                    if (free) begin
                        next_r.pcm = pred;
                        next_r.pv = 1'b1;
                        next_r.pright = pin.ch;
                        if (dlast) begin
                            pdone = 1'b1;
                        end else if (stereo) begin
                            next_r.sub = !r.sub;
                            if (r.sub) begin
                                if (r.j == XAD_WORD_LAST) begin
                                    next_r.j = '0;
                                    next_r.grp = r.grp + 2'h1;
                                end else begin
                                    next_r.j = r.j + 5'h01;
                                end
                            end
                        end else begin
                            if (r.j == XAD_WORD_LAST) begin
                                next_r.j = '0;
                                next_r.sub = !r.sub;
                                if (r.sub) begin
                                    next_r.grp = r.grp + 2'h1;
                                end
                            end else begin
                                next_r.j = r.j + 5'h01;
                            end
                        end
                    end
                end
                XAD_SKIP: begin
                    next_r.st = XAD_SKIP;
                end
                default: begin
                    next_r.st = XAD_HDR;
                end
            endcase
        end
        if (pdone) begin
            next_r.pidx = '0;
            next_r.herr = '0;
            next_r.perr = 1'b0;
            if (r.por == XAD_PORTION_LAST) begin
                next_r.st = XAD_SKIP;
            end else begin
                next_r.por = r.por + 5'h01;
                next_r.st = XAD_FILL;
            end
        end
        next_r.rdy = (next_r.st != XAD_DEC);

        // register bus: write side
        if (AWVALID_I && r.awrdy) begin
            next_r.aw_got = 1'b1;
            next_r.awa = AWADDR_I;
        end
        if (WVALID_I && r.wrdy) begin
            next_r.w_got = 1'b1;
            next_r.wd = WDATA_I;
            next_r.ws = WSTRB_I;
        end
        if (r.bv && BREADY_I) begin
            next_r.bv = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bv) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bv = 1'b1;
            next_r.bresp = XAD_OKAY;
            case (r.awa)
                XAD_CTRL_OFS: begin
                    for (int i = 0; i < 4; i++) begin
                        if (r.ws[i]) begin
                            next_r.ctrl[8 * i +: 8] = r.wd[8 * i +: 8];
                        end
                    end
                    next_r.ctrl = next_r.ctrl & XAD_CTRL_MASK;
                end
                XAD_STAT_OFS, XAD_CNT_OFS: next_r.bresp = XAD_OKAY;
                default: next_r.bresp = XAD_SLVERR;
            endcase
        end
        next_r.awrdy = !next_r.aw_got;
        next_r.wrdy = !next_r.w_got;

        // register bus: read side
        if (r.rv && RREADY_I) begin
            next_r.rv = 1'b0;
        end
        if (ARVALID_I && r.arrdy) begin
            next_r.rv = 1'b1;
            next_r.rresp = XAD_OKAY;
            case (ARADDR_I)
                XAD_CTRL_OFS: next_r.rd = r.ctrl;
                XAD_STAT_OFS: next_r.rd = {15'h0000, (r.st == XAD_FILL) || (r.st == XAD_DEC),
                    r.cod, 4'h0, r.cod[6], r.cod[2], eight, stereo};
                XAD_CNT_OFS: next_r.rd = {r.nerr, r.nsec};
                default: begin
                    next_r.rd = 32'h00000000;
                    next_r.rresp = XAD_SLVERR;
                end
            endcase
        end
        next_r.arrdy = !next_r.rv;
    end

    // ----------------------------------------------------------------
    // state and portion store
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (acc && !SEC_FIRST_I && (r.st == XAD_FILL)) begin
            mem[r.pidx] <= SEC_DATA_I;
        end
    end

    assign SEC_READY_O = r.rdy;
    assign PCM_O = r.pcm;
    assign PCM_RIGHT_O = r.pright;
    assign PCM_VALID_O = r.pv;
    assign AWREADY_O = r.awrdy;
    assign WREADY_O = r.wrdy;
    assign BRESP_O = r.bresp;
    assign BVALID_O = r.bv;
    assign ARREADY_O = r.arrdy;
    assign RDATA_O = r.rd;
    assign RRESP_O = r.rresp;
    assign RVALID_O = r.rv;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    property p_stall;
        (r.st == XAD_DEC) |-> !SEC_READY_O;
    endproperty
    a_stall: assert property (p_stall) else $error("input taken while decoding");

    property p_hold;
        (PCM_VALID_O && !PCM_READY_I) |=> PCM_VALID_O && $stable(PCM_O) && $stable(PCM_RIGHT_O);
    endproperty
    a_hold: assert property (p_hold) else $error("sample changed before accept");

    property p_shift;
        (r.st == XAD_DEC && par[3:0] > XAD_SHIFT_MAX) |-> (pin.smp == 16'($signed(wide) >>> XAD_SHIFT_ALT));
    endproperty
    a_shift: assert property (p_shift) else $error("reserved shift not mapped");

    property p_skip;
        (r.st == XAD_HDR && acc && !SEC_FIRST_I && r.hcnt == XAD_SUBHDR_LAST && !match)
            |=> (r.st == XAD_SKIP);
    endproperty
    a_skip: assert property (p_skip) else $error("unselected sector not skipped");

    property p_last;
        (r.st == XAD_DEC && free && dlast && r.por == XAD_PORTION_LAST) |=> (r.st == XAD_SKIP);
    endproperty
    a_last: assert property (p_last) else $error("decode ran past portion 18");

    property p_side;
        (r.st == XAD_DEC && free && stereo) |=> PCM_VALID_O && (PCM_RIGHT_O == $past(r.sub));
    endproperty
    a_side: assert property (p_side) else $error("stereo block on wrong side");

    property p_bresp;
        (r.aw_got && r.w_got && !r.bv) |=> BVALID_O ##1 (!BVALID_O || !$past(BREADY_I));
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response missing");
endmodule
`default_nettype wire

// ### xad_src.sv
// byte-stream model of the sector reader that feeds the decoder
`timescale 1ns/100ps
`default_nettype none
module xad_src (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic ready_i,
    output logic [7:0] data_o,
    output logic valid_o,
    output logic first_o,
    output logic err_o,
    output logic busy_o
);
    logic [7:0] mem [0:2331];
    logic err_at [0:2331];
    int idx;
    initial begin
        {data_o, valid_o, first_o, err_o, busy_o} = 12'h000;
        idx = 0;
    end
    // subheader, copy, then 914h payload bytes; random idle gaps after a take
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            idx = 0;
            busy_o <= 1'b1;
            valid_o <= 1'b1;
            first_o <= 1'b1;
            data_o <= mem[0];
            err_o <= err_at[0];
        end else if (busy_o && (!valid_o || ready_i)) begin
            idx = idx + int'(valid_o);
            first_o <= 1'b0;
            if (idx == 2332 || $urandom % 8 == 0) begin
                busy_o <= (idx != 2332);
                valid_o <= 1'b0;
                data_o <= ~data_o;
                err_o <= ~err_o;
            end else begin
                valid_o <= 1'b1;
                data_o <= mem[idx];
                err_o <= err_at[idx];
            end
        end
    end
endmodule
`default_nettype wire

// ### xa_adpcm_sector_decoder_test.sv
// self-checking testbench of the audio sector decoder
`timescale 1ns/100ps
`default_nettype none
module xa_adpcm_sector_decoder_test
    import xad_pkg::*;
;
    logic clk, rstn, go, pcm_rdy, awv, wv, bry, arv, rry, sv, sf, se, srdy, sbusy, prt, pv, awr, wr, arr, bv, rv;
    logic [7:0] awa, ara, sd, fsel, cod;
    logic [4:0] csel;
    logic [31:0] wd, rd_v, rdat;
    logic [1:0] rs_v, br, rr;
    logic [15:0] pcm;
    int err_total, n_tests, ho[2], hoo[2];
    logic [16:0] q[$];
    const int F0[4] = '{0, 60, 115, 98};
    const int F1[4] = '{0, 0, -52, -55};

    xad_src src (.clk_i(clk), .go_i(go), .ready_i(srdy), .data_o(sd), .valid_o(sv), .first_o(sf), .err_o(se),
        .busy_o(sbusy));
    xad_decoder dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .SEC_DATA_I(sd), .SEC_VALID_I(sv), .SEC_FIRST_I(sf),
        .SEC_ERR_I(se), .SEC_READY_O(srdy), .PCM_O(pcm), .PCM_RIGHT_O(prt), .PCM_VALID_O(pv),
        .PCM_READY_I(pcm_rdy), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
        .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wr), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bry),
        .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdat), .RRESP_O(rr), .RVALID_O(rv),
        .RREADY_I(rry));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task axw(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge clk);
        {awa, wd, awv, wv, bry} <= {a, d, 3'h7};
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awv && awr) begin ad = 1; awv <= 0; end
            if (wv && wr) begin dd = 1; wv <= 0; end
        end
        while (!bv) @(posedge clk);
        bry <= 0;
        chk({30'h0, br}, {30'h0, XAD_OKAY});
    endtask

    task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {ara, arv, rry} <= {a, 2'h3};
        do @(posedge clk); while (!(arv && arr));
        arv <= 0;
        while (!rv) @(posedge clk);
        d = rdat;
        r = rr;
        rry <= 0;
    endtask

    task send(input logic [7:0] f, input logic [4:0] c, input logic [7:0] sm, input logic [7:0] cd, input bit hit,
        input int bad);
        int blk, j, p, par, sh, t, s, ch;
        for (int i = 0; i < 2332; i++) begin
            src.mem[i] = 8'($urandom);
            src.err_at[i] = 1'b0;
        end
        {src.mem[0], src.mem[1], src.mem[2], src.mem[3]} = {f, 3'h0, c, sm, cd};
        for (int i = 0; i < 4; i++) src.mem[4 + i] = src.mem[i];
        for (int i = 0; i < 72; i++) begin
            src.mem[8 + 128 * (i / 4) + i % 4] = src.mem[12 + 128 * (i / 4) + i % 4];
            src.mem[20 + 128 * (i / 4) + i % 4] = src.mem[16 + 128 * (i / 4) + i % 4];
        end
        for (int i = 0; i < 18 && hit; i++) for (int o = 0; o < (cd[4] ? 112 : 224); o++) begin
            p = 8 + 128 * i;
            if (i == bad && !sm[6]) break;
            if (cd[0]) begin blk = (o / 56) * 2 + o % 2; j = (o % 56) / 2; ch = o % 2; end
            else begin blk = o / 28; j = o % 28; ch = 0; end
            par = src.mem[p + 4 + blk];
            sh = (par % 16 > 12) ? 9 : par % 16;
            if (cd[4]) t = 256 * int'($signed(src.mem[p + 16 + 4 * j + blk]));
            else t = 4096 * (((src.mem[p + 16 + 4 * j + blk / 2] >> (4 * (blk % 2))) % 16 + 8) % 16 - 8);
            s = (t >>> sh) + ((ho[ch] * F0[par / 16 % 4] + hoo[ch] * F1[par / 16 % 4] + 32) >>> 6);
            s = s > 32767 ? 32767 : (s < -32768 ? -32768 : s);
            hoo[ch] = ho[ch];
            ho[ch] = s;
            q.push_back({ch[0], s[15:0]});
        end
        if (bad >= 0) begin
            src.err_at[12 + 128 * bad] = 1'b1;
            src.mem[12 + 128 * bad] = ~src.mem[12 + 128 * bad];
        end
        go <= 1;
        @(posedge clk);
        go <= 0;
        repeat (2) @(posedge clk);
        while (sbusy) @(posedge clk);
    endtask

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) pcm_rdy <= ($urandom % 4 != 0);

    always @(posedge clk) if (rstn && pv && pcm_rdy) begin
        chk({15'h0, prt, pcm}, q.size() != 0 ? {15'h0, q.pop_front()} : 32'hFFFFFFFF);
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        close_out;
    end

    initial begin
        void'($urandom(32'hE472F1DE));
        {rstn, go, pcm_rdy, awv, wv, bry, arv, rry, awa, ara, wd} = 0;
        {err_total, n_tests, ho[0], ho[1], hoo[0], hoo[1]} = 0;
        repeat (12) @(posedge clk);
        rstn <= 1;
        repeat (2) @(posedge clk);
        fsel = 8'($urandom);
        csel = 5'($urandom);
        axw(XAD_CTRL_OFS, {11'h0, csel, fsel, 8'h01});
        axr(XAD_CTRL_OFS, rd_v, rs_v);
        chk(rd_v, {11'h0, csel, fsel, 8'h01});
        for (int k = 0; k < 8; k++) begin
            cod = {1'b0, 1'($urandom), 1'b0, 1'(k / 4), 1'b0, 1'($urandom), 1'b0, 1'(k / 2)};
            send(k == 1 ? fsel + 8'h01 : fsel, k == 3 ? csel ^ 5'h01 : csel,
                k == 2 ? 8'h24 : (k == 5 ? 8'h62 : (k == 7 ? 8'h44 : 8'h64)), cod, k % 2 == 0,
                k == 2 ? 3 : (k == 6 ? 0 : -1));
        end
        while (q.size() != 0) @(posedge clk);
        axr(XAD_CNT_OFS, rd_v, rs_v);
        chk(rd_v, 32'h00010004);
        axr(XAD_STAT_OFS, rd_v, rs_v);
        chk(rd_v, {16'h0000, cod, 4'h0, cod[6], cod[2], cod[4], cod[0]});
        axr(8'h0C, rd_v, rs_v);
        chk({30'h0, rs_v}, {30'h0, XAD_SLVERR});
        chk(rd_v, 32'h00000000);
        close_out;
    end
endmodule
`default_nettype wire
